// ==== rtl/bchft_fifo_xfer.v ====
// b-channel hdlc receive/transmit fifo host transfer logic
`timescale 1ns/1ps
`default_nettype none
`include "bchft_map.vh"
module bchft_fifo_xfer #(
  parameter DEPTH = 64,
  parameter AW    = 6
) (
  input  wire       clock_i,
  input  wire       rstn_i,
  input  wire [7:0] addr_i,
  input  wire       cs_n_i,
  input  wire       rd_n_i,
  input  wire       wr_n_i,
  input  wire [7:0] data_i,
  output reg  [7:0] data_o,
  output wire       data_oe_n_o,
  output wire       rx_dma_request_o,
  output wire       tx_dma_request_o,
  input  wire [7:0] rx_byte_i,
  input  wire       rx_last_i,
  input  wire       rx_valid_i,
  output wire       rx_ready_o,
  output wire [7:0] tx_byte_o,
  output wire       tx_valid_o,
  input  wire       tx_ready_i,
  output reg        tx_send_o
);
  // window decode: 00-1F aliased at 40-5F
  function is_fifo;
    input [7:0] a;
    begin
      is_fifo = ~a[7] & ~a[5];
    end
  endfunction
  function reg_hit;
    input [7:0] a;
    input [5:0] off;
    begin
      reg_hit = ~a[7] & (a[5:0] == off);
    end
  endfunction
  // burst size for a short or last block
  function [6:0] round_up;
    input [6:0] n;
    begin
      if (n <= 7'd3)
        round_up = 7'd4;
      else if (n <= 7'd7)
        round_up = 7'd8;
      else if (n <= 7'd15)
        round_up = 7'd16;
      else if (n <= 7'd31)
        round_up = 7'd32;
      else
        round_up = 7'd64;
    end
  endfunction

  // host strobe tracking
  wire       rd_act = ~cs_n_i & ~rd_n_i;
  wire       wr_act = ~cs_n_i & ~wr_n_i;
  reg        rd_q;
  reg        wr_q;
  reg  [7:0] addr_q;
  reg  [7:0] wdat_q;
  wire       rd_end = rd_q & ~rd_act;
  wire       wr_end = wr_q & ~wr_act;
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rd_q   <= 1'b0;
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
      wdat_q <= 8'h00;
    end
    else
    begin
      rd_q <= rd_act;
      wr_q <= wr_act;
      if (rd_act | wr_act)
        addr_q <= addr_i;
      if (wr_act)
        wdat_q <= data_i;
    end
  end
  // any window address hits the fifo
  wire rx_pop_host = rd_end & is_fifo(addr_q);
  wire tx_push     = wr_end & is_fifo(addr_q);
  wire cmd_wr      = wr_end & reg_hit(addr_q, `BCHFT_OFF_COMMAND);
  wire rx_release_cmd         = cmd_wr & wdat_q[`BCHFT_CMD_RMC];
  wire xres        = cmd_wr & wdat_q[`BCHFT_CMD_XRES];
  wire xgo         = cmd_wr & (wdat_q[`BCHFT_CMD_XTF] | wdat_q[`BCHFT_CMD_XIF]);

  // software registers
  reg        dma_mode;
  reg [11:0] tx_len;
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dma_mode <= 1'b0;
      tx_len   <= `BCHFT_TXCNT_RST;
    end
    else if (wr_end & reg_hit(addr_q, `BCHFT_OFF_TXCNT_LO))
      tx_len[7:0] <= wdat_q;
    else if (wr_end & reg_hit(addr_q, `BCHFT_OFF_TXCNT_HI))
    begin
      // mode bit in transmit count high
      dma_mode     <= wdat_q[`BCHFT_HI_DMA];
      tx_len[11:8] <= wdat_q[3:0];
    end
  end

  // two-entry buffer ahead of the receive fifo
  reg  [8:0] sk_mem [0:1];
  reg        sk_wp;
  reg        sk_rp;
  reg  [1:0] sk_cnt;
  wire       sk_valid = (sk_cnt != 2'd0);
  wire [8:0] sk_head  = sk_mem[sk_rp];
  assign rx_ready_o = (sk_cnt != 2'd2);
  wire       sk_in  = rx_valid_i & rx_ready_o;
  wire       rx_acc;
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sk_wp     <= 1'b0;
      sk_rp     <= 1'b0;
      sk_cnt    <= 2'd0;
      sk_mem[0] <= 9'h000;
      sk_mem[1] <= 9'h000;
    end
    else
    begin
      if (sk_in)
      begin
        sk_mem[sk_wp] <= {rx_last_i, rx_byte_i};
        sk_wp         <= ~sk_wp;
      end
      if (rx_acc)
        sk_rp <= ~sk_rp;
      sk_cnt <= sk_cnt + {1'b0, sk_in} - {1'b0, rx_acc};
    end
  end

  // receive fifo and block bookkeeping
  reg  [7:0]    rx_mem [0:DEPTH-1];
  reg  [AW:0]   rx_wp;
  reg  [AW:0]   rx_rp;
  reg  [6:0]    seg_cnt;
  reg           seg_end;
  reg           blk_open;
  reg           blk_last;
  reg  [6:0]    blk_len;
  reg  [6:0]    blk_done;
  reg  [AW:0]   blk_endp;
  reg  [11:0]   frm_cnt;
  reg  [11:0]   rbc;
  reg           rbc_ov;
  wire [AW:0]   rx_cnt   = rx_wp - rx_rp;
  // 64 bytes of storage behind the window
  assign rx_acc = sk_valid & (rx_cnt < DEPTH) & ~seg_end;
  wire          open_now = ~blk_open & (seg_end | (seg_cnt == `BCHFT_FULL_BLOCK));
  wire [6:0]    open_len = seg_end ? seg_cnt : `BCHFT_FULL_BLOCK;
  wire [6:0]    burst    = blk_last ? round_up(blk_len) : `BCHFT_FULL_BLOCK;
  wire          burst_ok = dma_mode & blk_open & (blk_done == burst);
  wire          dma_rel  = burst_ok & ~blk_last;
  wire          blk_free = dma_rel | (rx_release_cmd & blk_open);
  // pool full only outside dma mode
  wire          ev_rpf   = open_now & ~seg_end & ~dma_mode;
  // dma message end after last read
  wire          ev_rme   = (open_now & seg_end & ~dma_mode) |
                           (dma_mode & blk_open & blk_last & rx_pop_host &
                            (blk_done == burst - 7'd1));
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rx_wp    <= {(AW+1){1'b0}};
      rx_rp    <= {(AW+1){1'b0}};
      seg_cnt  <= 7'd0;
      seg_end  <= 1'b0;
      blk_open <= 1'b0;
      blk_last <= 1'b0;
      blk_len  <= 7'd0;
      blk_done <= 7'd0;
      blk_endp <= {(AW+1){1'b0}};
      frm_cnt  <= 12'h000;
      rbc      <= 12'h000;
      rbc_ov   <= 1'b0;
    end
    else
    begin
      if (rx_acc)
      begin
        rx_mem[rx_wp[AW-1:0]] <= sk_head[7:0];
        rx_wp                 <= rx_wp + 1'b1;
        frm_cnt               <= sk_head[8] ? 12'h000 : frm_cnt + 12'h001;
        if (sk_head[8])
        begin
          rbc    <= frm_cnt + 12'h001;
          rbc_ov <= (frm_cnt == 12'hFFF);
        end
        seg_end <= sk_head[8];
      end
      seg_cnt <= seg_cnt + {6'd0, rx_acc} - (open_now ? open_len : 7'd0);
      if (open_now)
      begin
        // last flag set when block holds whole message or its last part
        blk_open <= 1'b1;
        blk_last <= seg_end;
        blk_len  <= open_len;
        blk_done <= 7'd0;
        blk_endp <= rx_rp + open_len;
        seg_end  <= 1'b0;
      end
      else if (blk_free)
      begin
        // last dma block waits for release command
        blk_open <= 1'b0;
        rx_rp    <= blk_endp;
      end
      else if (rx_pop_host & blk_open)
      begin
        if (blk_done != 7'h7F)
          blk_done <= blk_done + 7'd1;
        if (rx_rp != blk_endp)
          rx_rp <= rx_rp + 1'b1;
      end
    end
  end
  // request held over the full block
  // full block drops when chip select falls for read 64, short at last read start
  // re-request while chip select high and reads missing
  // pending read end counted, so no blip after the last read
  wire [7:0] rd_seen  = {1'b0, blk_done} + {7'd0, rx_pop_host};
  wire [7:0] burst_m1 = {1'b0, burst} - 8'd1;
  wire rq_full  = (rd_seen < 8'd63) | ((rd_seen < 8'd64) & cs_n_i);
  wire rq_short = (rd_seen < burst_m1) | ((rd_seen == burst_m1) & ~rd_act);
  assign rx_dma_request_o = dma_mode & blk_open & (blk_last ? rq_short : rq_full);

  // transmit fifo and dma block sequencing
  reg  [7:0]  tx_mem [0:DEPTH-1];
  reg  [AW:0] tx_wp;
  reg  [AW:0] tx_rp;
  reg  [12:0] tx_rem;
  reg         tx_bact;
  reg  [6:0]  tx_blk;
  reg  [6:0]  tx_done;
  reg         tx_was;
  wire [AW:0] tx_cnt   = tx_wp - tx_rp;
  wire        tx_pop   = tx_valid_o & tx_ready_i;
  wire [6:0]  next_blk = (tx_rem > 13'd64) ? `BCHFT_FULL_BLOCK : tx_rem[6:0];
  wire        tx_start = dma_mode & ~tx_bact & (tx_rem != 13'd0) &
                         ((DEPTH - tx_cnt) >= next_blk);
  assign tx_valid_o = (tx_cnt != {(AW+1){1'b0}});
  assign tx_byte_o  = tx_mem[tx_rp[AW-1:0]];
  wire ev_xpr = xres | (~dma_mode & tx_was & ~tx_valid_o);
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tx_wp     <= {(AW+1){1'b0}};
      tx_rp     <= {(AW+1){1'b0}};
      tx_rem    <= 13'd0;
      tx_bact   <= 1'b0;
      tx_blk    <= 7'd0;
      tx_done   <= 7'd0;
      tx_was    <= 1'b0;
      tx_send_o <= 1'b0;
    end
    else
    begin
      tx_was    <= tx_valid_o;
      tx_send_o <= xgo | (cmd_wr & wdat_q[`BCHFT_CMD_XME]);
      if (xres)
      begin
        tx_rp   <= tx_wp;
        tx_rem  <= 13'd0;
        tx_bact <= 1'b0;
      end
      else
      begin
        // host fills up to 64 bytes, excess dropped
        if (tx_push & (tx_cnt < DEPTH))
        begin
          tx_mem[tx_wp[AW-1:0]] <= wdat_q;
          tx_wp                 <= tx_wp + 1'b1;
        end
        if (tx_pop)
          tx_rp <= tx_rp + 1'b1;
        if (xgo & dma_mode)
        begin
          // programmed count plus one bytes requested
          tx_rem <= {1'b0, tx_len} + 13'd1;
        end
        else if (tx_start)
        begin
          tx_bact <= 1'b1;
          tx_blk  <= next_blk;
          tx_done <= 7'd0;
        end
        else if (tx_bact & (tx_done == tx_blk))
        begin
          tx_bact <= 1'b0;
          tx_rem  <= tx_rem - {6'd0, tx_blk};
        end
        else if (tx_bact & tx_push)
          tx_done <= tx_done + 7'd1;
      end
    end
  end
  // re-request at chip select high if last write missing
  wire [7:0] tx_seen = {1'b0, tx_done} + {7'd0, tx_push};
  assign tx_dma_request_o = tx_bact & (tx_seen < {1'b0, tx_blk}) &
                            ((tx_seen < {1'b0, tx_blk} - 8'd1) | cs_n_i);

  // event register, cleared by its read, set wins
  reg [7:0] ev_stat;
  wire      ev_clr = rd_end & reg_hit(addr_q, `BCHFT_OFF_EVENT);
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ev_stat <= `BCHFT_EVENT_RST;
    else
    begin
      ev_stat <= ev_clr ? 8'h00 : ev_stat;
      if (ev_rme)
        ev_stat[`BCHFT_EV_RME] <= 1'b1;
      if (ev_rpf)
        ev_stat[`BCHFT_EV_RPF] <= 1'b1;
      if (ev_xpr)
        ev_stat[`BCHFT_EV_XPR] <= 1'b1;
    end
  end

  // read data mux
  reg [7:0] next_data;
  always @*
  begin
    next_data = 8'h00;
    if (is_fifo(addr_i))
      next_data = rx_mem[rx_rp[AW-1:0]];
    else if (reg_hit(addr_i, `BCHFT_OFF_EVENT))
      next_data = ev_stat;
    else if (reg_hit(addr_i, `BCHFT_OFF_STATUS))
    begin
      next_data[`BCHFT_ST_XFW] = (tx_cnt < DEPTH);
      next_data[`BCHFT_ST_RFR] = blk_open;
    end
    else if (reg_hit(addr_i, `BCHFT_OFF_RXCNT_LO))
      next_data = rbc[7:0];
    else if (reg_hit(addr_i, `BCHFT_OFF_RXCNT_HI))
      next_data = {dma_mode, 2'b00, rbc_ov, rbc[11:8]};
  end
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      data_o <= 8'h00;
    else if (rd_act)
      data_o <= next_data;
  end
  assign data_oe_n_o = ~rd_q;
endmodule // bchft_fifo_xfer
`default_nettype wire

// ==== rtl/bchft_map.vh ====
// register offsets, field positions and reset values for the b-channel fifo transfer block
`ifndef BCHFT_MAP_VH
`define BCHFT_MAP_VH
`define BCHFT_OFF_EVENT     6'h20
`define BCHFT_OFF_STATUS    6'h21
`define BCHFT_OFF_COMMAND   6'h21
`define BCHFT_OFF_RXCNT_LO  6'h25
`define BCHFT_OFF_TXCNT_LO  6'h2A
`define BCHFT_OFF_RXCNT_HI  6'h2D
`define BCHFT_OFF_TXCNT_HI  6'h2D
`define BCHFT_EV_RME        7
`define BCHFT_EV_RPF        6
`define BCHFT_EV_XPR        4
`define BCHFT_CMD_RMC       7
`define BCHFT_CMD_XTF       3
`define BCHFT_CMD_XIF       2
`define BCHFT_CMD_XME       1
`define BCHFT_CMD_XRES      0
`define BCHFT_HI_DMA        7
`define BCHFT_HI_OV         4
`define BCHFT_ST_XFW        6
`define BCHFT_ST_RFR        4
`define BCHFT_EVENT_RST     8'h00
`define BCHFT_TXCNT_RST     12'h000
`define BCHFT_FULL_BLOCK    7'h40
`endif

// ==== verification/bchft_properties.sv ====
// assertion checker for the b-channel fifo transfer ports
`timescale 1ns/1ps
`default_nettype none
module bchft_properties (
  input wire       clock_i,
  input wire       rstn_i,
  input wire       cs_n_i,
  input wire       rd_n_i,
  input wire [7:0] data_o,
  input wire       data_oe_n_o,
  input wire       rx_dma_request_o,
  input wire       tx_dma_request_o,
  input wire       rx_valid_i,
  input wire       rx_ready_o,
  input wire       tx_send_o
);
  wire racc = !cs_n_i && !rd_n_i;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_quiet;
    !racc ##1 !racc;
  endsequence
  property p_oe_on;
    racc |=> !data_oe_n_o;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("bus not driven in read");
  property p_oe_off;
    s_quiet |-> data_oe_n_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus driven while idle");
  property p_data_hold;
    s_quiet |-> $stable(data_o);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("read data moved");
  property p_rx_keep;
    rx_dma_request_o && cs_n_i ##1 cs_n_i |-> rx_dma_request_o;
  endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("rx request lost");
  property p_tx_keep;
    tx_dma_request_o && cs_n_i ##1 cs_n_i |-> tx_dma_request_o;
  endproperty
  a_tx_keep: assert property (p_tx_keep) else $error("tx request lost");
  property p_rx_drop;
    $fell(rx_dma_request_o) |-> !cs_n_i || !$past(cs_n_i);
  endproperty
  a_rx_drop: assert property (p_rx_drop) else $error("rx request fell idle");
  property p_send_pulse;
    tx_send_o |=> !tx_send_o;
  endproperty
  a_send_pulse: assert property (p_send_pulse) else $error("send too long");
  property p_rx_hold;
    rx_ready_o && !rx_valid_i |=> rx_ready_o;
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("ready fell unfed");
endmodule // bchft_properties
bind bchft_fifo_xfer bchft_properties bchft_properties_i (
  .clock_i(clock_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i),
  .data_o(data_o), .data_oe_n_o(data_oe_n_o), .rx_dma_request_o(rx_dma_request_o),
  .tx_dma_request_o(tx_dma_request_o), .rx_valid_i(rx_valid_i),
  .rx_ready_o(rx_ready_o), .tx_send_o(tx_send_o));
`default_nettype wire

// ==== verification/bchft_line_model.sv ====
// line side model: frame source and stalling byte sink
`timescale 1ns/1ps
`default_nettype none
module bchft_line_model (
  input  wire       clock_i,
  input  wire       rstn_i,
  input  wire [7:0] len_i,
  input  wire       go_i,
  output wire [7:0] rx_byte_o,
  output wire       rx_last_o,
  output wire       rx_valid_o,
  input  wire       rx_ready_i,
  input  wire       tx_valid_i,
  input  wire [7:0] tx_byte_i,
  output reg        tx_ready_o,
  output reg  [7:0] taken_o,
  output reg  [7:0] sum_o
);
  reg [7:0] left;
  reg [7:0] idx;
  assign rx_valid_o = left != 8'h00;
  assign rx_last_o  = left == 8'h01;
  // inverted data while idle
  assign rx_byte_o  = rx_valid_o ? idx ^ 8'hA5 : ~(idx ^ 8'hA5);
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      left <= 8'h00;
      idx <= 8'h00;
      tx_ready_o <= 1'b0;
      taken_o <= 8'h00;
      sum_o <= 8'h00;
    end
    else
    begin
      tx_ready_o <= !tx_ready_o;
      if (tx_valid_i && tx_ready_o)
      begin
        taken_o <= taken_o + 8'h01;
        sum_o <= sum_o + tx_byte_i;
      end
      if (go_i)
      begin
        left <= len_i;
        idx <= 8'h00;
      end
      else if (rx_valid_o && rx_ready_i)
      begin
        left <= left - 8'h01;
        idx <= idx + 8'h01;
      end
    end
  end
endmodule // bchft_line_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the b-channel fifo transfer block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  reg        clock_i = 1'b0;
  reg        rstn_i = 1'b0;
  reg  [7:0] addr = 8'h00;
  reg  [7:0] wdata = 8'h00;
  reg  [7:0] len = 8'h00;
  reg        cs_n = 1'b1;
  reg        rd_n = 1'b1;
  reg        wr_n = 1'b1;
  reg        go = 1'b0;
  reg  [7:0] d, n, e;
  wire [7:0] rdata, rx_byte, taken, tx_byte, sum;
  wire       rx_req, tx_req, rx_last, rx_valid, rx_ready, tx_valid, tx_ready, tx_send;
  integer    bad_count = 0;
  integer    samples_checked = 0;
  integer    i, j, k, t;
  always #2 clock_i = ~clock_i;
  bchft_fifo_xfer bchft_fifo_xfer_i (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr),
    .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(wdata), .data_o(rdata),
    .data_oe_n_o(), .rx_dma_request_o(rx_req), .tx_dma_request_o(tx_req),
    .rx_byte_i(rx_byte), .rx_last_i(rx_last), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
    .tx_byte_o(tx_byte), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .tx_send_o(tx_send));
  bchft_line_model bchft_line_model_i (.clock_i(clock_i), .rstn_i(rstn_i), .len_i(len),
    .go_i(go), .rx_byte_o(rx_byte), .rx_last_o(rx_last), .rx_valid_o(rx_valid),
    .rx_ready_i(rx_ready), .tx_valid_i(tx_valid), .tx_byte_i(tx_byte), .tx_ready_o(tx_ready),
    .taken_o(taken), .sum_o(sum));
  task stop_test;
  begin
    if (bad_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  end
  endtask
  task lim;
  begin
    if (t >= 3000)
    begin
      bad_count = bad_count + 1;
      $display("Error at %0t: wait expired", $time);
      stop_test;
    end
  end
  endtask
  task tick;
  begin
    @(posedge clock_i);
    #1;
    t = t + 1;
  end
  endtask
  task acc(input [7:0] a, input [7:0] dw, input w);
  begin
    @(posedge clock_i);
    addr <= a;
    wdata <= dw;
    cs_n <= 1'b0;
    rd_n <= w;
    wr_n <= !w;
    @(posedge clock_i);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    #1 d = rdata;
    tick;
  end
  endtask
  task wait_open;
  begin
    t = 0;
    d = 8'h00;
    while (d[4] !== 1'b1 && t < 3000)
      acc(8'h21, 8'h00, 1'b0);
    lim;
  end
  endtask
  task rd_bytes(input integer first, input integer cnt);
  begin
    for (i = first; i < first + cnt; i = i + 1)
    begin
      acc({1'b0, i[5], 1'b0, i[4:0]}, 8'h00, 1'b0);
      chk(d, i[7:0] ^ 8'hA5);
    end
  end
  endtask
  task send(input [7:0] cnt);
  begin
    @(posedge clock_i);
    len <= cnt;
    go <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
  end
  endtask
  task dma_rx(input [7:0] exp, input last);
  begin
    t = 0;
    while (rx_req !== 1'b1 && t < 3000)
      tick;
    lim;
    for (k = 0; rx_req === 1'b1 && k < exp; k = k + 1)
      acc({1'b0, k[5], 1'b0, k[4:0]}, 8'h00, 1'b0);
    chk(k[7:0], exp);
    if (last)
      chk({7'h00, rx_req}, 8'h00);
    acc(8'h20, 8'h00, 1'b0);
    chk(d, {last, 7'h00});
  end
  endtask
  task dma_tx(input [7:0] cnt, input [7:0] cmd);
  begin
    acc(8'h2A, cnt - 8'h01, 1'b1);
    acc(8'h2D, 8'h80, 1'b1);
    acc(8'h21, cmd, 1'b1);
    chk({7'h00, tx_send}, 8'h01);
    t = 0;
    for (k = 0; k < cnt && t < 3000; k = k)
      if (tx_req !== 1'b1)
        tick;
      else
      begin
        if (k == cnt - 1)
        begin
          @(posedge clock_i);
          cs_n <= 1'b0;
          #1 chk({7'h00, tx_req}, 8'h00);
          @(posedge clock_i);
          cs_n <= 1'b1;
          #1 chk({7'h00, tx_req}, 8'h01);
        end
        acc({1'b0, k[5], 1'b0, k[4:0]}, k[7:0], 1'b1);
        k = k + 1;
      end
    lim;
    chk({7'h00, tx_req}, 8'h00);
  end
  endtask
  initial
  begin
    repeat (20) @(posedge clock_i);
    rstn_i <= 1'b1;
    acc(8'h2D, 8'h00, 1'b0);
    chk(d, 8'h00);
    acc(8'h24, 8'h00, 1'b0);
    chk(d, 8'h00);
    acc(8'h21, 8'h01, 1'b1);
    acc(8'h20, 8'h00, 1'b0);
    chk(d, 8'h10);
    acc(8'h60, 8'h00, 1'b0);
    chk(d, 8'h00);
    send(8'h46);
    wait_open;
    acc(8'h20, 8'h00, 1'b0);
    chk(d, 8'h40);
    rd_bytes(0, 64);
    acc(8'h21, 8'h80, 1'b1);
    wait_open;
    acc(8'h20, 8'h00, 1'b0);
    chk(d, 8'h80);
    acc(8'h25, 8'h00, 1'b0);
    chk(d, 8'h46);
    rd_bytes(64, 6);
    acc(8'h21, 8'h80, 1'b1);
    acc(8'h2D, 8'h80, 1'b1);
    for (j = 0; j < 6; j = j + 1)
    begin
      e = (j < 5) ? (8'h04 << j) : 8'h04;
      n = (j < 5) ? e - 8'h01 : 8'h42;
      send(n);
      if (j == 5)
        dma_rx(8'h40, 1'b0);
      dma_rx(e, 1'b1);
      chk({7'h00, rx_req}, 8'h00);
      acc(8'h25, 8'h00, 1'b0);
      chk(d, n);
      acc(8'h21, 8'h80, 1'b1);
    end
    dma_tx(8'h03, 8'h08);
    dma_tx(8'h42, 8'h04);
    t = 0;
    while (taken !== 8'h45 && t < 3000)
      tick;
    lim;
    chk(taken, 8'h45);
    chk(sum, 8'h64);
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
